// File: ctf_flags_load.sv
`timescale 1ns/1ps

// Function
// RL1 - Set low-charge flag when capacity left drops below set level, mAh.
// RL2 - Clear low-charge flag when capacity left climbs above set level.
// RL3 - Battery-low pin always follows the low-charge flag.
// RL4 - Voltage below shutdown set level sets warning flag and pulses int.
// RL5 - Set warning flag clears above shutdown clear level, pulsing int.
// RL6 - Load-model kind 0 (default) constant current, 1 constant power.
// RL7 - Status bit mirrors the load-model kind.
// RL8 - Current options: 0 last cycle, 1 (default) this cycle, 2 average.
// RL9 - Current options: 3 filtered 14 s, 4 capacity/5, 5 rate, 6 custom.
// RL10 - Power options: 0 (default) last cycle, 1 this cycle, 2 I times V.
// RL11 - Power options: 3 filtered I*V, 4 energy/5, 5 rate, 6 custom.
// RL12 - Record average discharge current per cycle; keep previous average.
// RL13 - Reserve charge remains after capacity zero until end voltage.
// RL14 - Accumulate measured charge to track state of charge.
// RL15 - Re-evaluate both flags on every measurement update.
module ctf_flags_load #(
    parameter int unsigned FILT_STEP = 32'(ctf_pkg::FILT_STEP_CYCLES)
) (
    input  wire logic                             CLK,
    input  wire logic                             SYS_RST,
    input  wire logic                             MEAS_UPDATE,
    input  wire logic [ctf_pkg::VAL_W-1:0]        CAPACITY_LEFT_VALUE,
    input  wire logic [ctf_pkg::VAL_W-1:0]        CELL_VOLTAGE,
    input  wire logic signed [ctf_pkg::VAL_W-1:0] MEAN_CURRENT_VALUE,
    input  wire logic signed [ctf_pkg::VAL_W-1:0] CHARGE_DELTA,
    input  wire logic [ctf_pkg::VAL_W-1:0]        INITIAL_CHARGE_SET_LEVEL,
    input  wire logic [ctf_pkg::VAL_W-1:0]        SHUTDOWN_SET_LEVEL,
    input  wire logic [ctf_pkg::VAL_W-1:0]        SHUTDOWN_CLEAR_LEVEL,
    input  wire logic [ctf_pkg::VAL_W-1:0]        TERMINATE_VOLTAGE,
    input  wire logic [ctf_pkg::VAL_W-1:0]        RESERVE_CHARGE_AMOUNT,
    input  wire logic [ctf_pkg::VAL_W-1:0]        DSG_THRESHOLD,
    input  wire logic [ctf_pkg::VAL_W-1:0]        DESIGN_CAPACITY,
    input  wire logic [ctf_pkg::VAL_W-1:0]        DESIGN_ENERGY,
    input  wire logic signed [ctf_pkg::VAL_W-1:0] HYPOTHETICAL_RATE_VALUE,
    input  wire logic signed [ctf_pkg::VAL_W-1:0] CUSTOM_RATE_VALUE,
    input  wire logic                             LOAD_MODEL_KIND,
    input  wire logic [2:0]                       LOAD_MODEL_OPTION,
    output logic                                  LOW_CHARGE_FLAG,
    output logic                                  SHUTDOWN_WARNING_FLAG,
    output logic                                  BATTERY_LOW_PIN,
    output logic                                  SOC_INT_PIN,
    output logic                                  LOAD_MODEL_STATUS_BIT,
    output logic signed [ctf_pkg::VAL_W-1:0]      LOAD_RATE_VALUE,
    output logic                                  LOAD_OPTION_INVALID,
    output logic signed [ctf_pkg::VAL_W-1:0]      AVG_I_LAST_RUN,
    output logic signed [ctf_pkg::VAL_W-1:0]      AVG_P_LAST_RUN,
    output logic signed [ctf_pkg::ACC_W-1:0]      CHARGE_ACCUM,
    output logic [ctf_pkg::VAL_W-1:0]             RESERVE_LEFT_VALUE
);

    logic                             next_low_charge;
    logic                             next_shutdown;
    logic                             dsg_now;
    logic                             in_dsg;
    logic [ctf_pkg::VAL_W-1:0]        dsg_count;
    logic [ctf_pkg::SUM_W-1:0]        sum_i;
    logic [ctf_pkg::SUM_W-1:0]        sum_p;
    logic                             div_start;
    logic                             div_i_done;
    logic                             div_p_done;
    logic [ctf_pkg::SUM_W-1:0]        quo_i;
    logic [ctf_pkg::SUM_W-1:0]        quo_p;
    logic signed [ctf_pkg::VAL_W-1:0] avg_i_now;
    logic signed [ctf_pkg::VAL_W-1:0] avg_p_now;
    logic signed [ctf_pkg::VAL_W-1:0] inst_power;
    logic signed [ctf_pkg::VAL_W-1:0] filt_cur;
    logic signed [ctf_pkg::VAL_W-1:0] next_rate;
    logic                             next_invalid;
    logic [31:0]                      filt_tick_cnt;
    logic signed [ctf_pkg::FILT_W-1:0] filt_acc;
    logic signed [ctf_pkg::FILT_W:0]   filt_diff;
    logic [ctf_pkg::RES_W-1:0]        reserve_left;
    logic [ctf_pkg::VAL_W:0]          draw;

    // Threshold flags; an equal reading leaves a flag as it was
    always_comb
    begin
        next_low_charge = LOW_CHARGE_FLAG;
        if (CAPACITY_LEFT_VALUE < INITIAL_CHARGE_SET_LEVEL)
            next_low_charge = 1'b1; // RL1
        else if (CAPACITY_LEFT_VALUE > INITIAL_CHARGE_SET_LEVEL)
            next_low_charge = 1'b0; // RL2
        next_shutdown = SHUTDOWN_WARNING_FLAG;
        if (CELL_VOLTAGE < SHUTDOWN_SET_LEVEL)
            next_shutdown = 1'b1; // RL4
        else if (SHUTDOWN_WARNING_FLAG
                 && CELL_VOLTAGE > SHUTDOWN_CLEAR_LEVEL)
            next_shutdown = 1'b0; // RL5
    end

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            LOW_CHARGE_FLAG <= 1'b0;
            BATTERY_LOW_PIN <= 1'b0;
        end
        else if (MEAS_UPDATE) // RL15
        begin
            LOW_CHARGE_FLAG <= next_low_charge;
            // Loaded from the same next value, so pin and flag never skew
            BATTERY_LOW_PIN <= next_low_charge; // RL3
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            SHUTDOWN_WARNING_FLAG <= 1'b0;
            SOC_INT_PIN           <= 1'b0;
        end
        else
        begin
            SOC_INT_PIN <= MEAS_UPDATE
                           && (next_shutdown != SHUTDOWN_WARNING_FLAG); // RL4
            if (MEAS_UPDATE) // RL15
                SHUTDOWN_WARNING_FLAG <= next_shutdown; // RL5
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            LOAD_MODEL_STATUS_BIT <= ctf_pkg::MODEL_DEFAULT;
        else
            LOAD_MODEL_STATUS_BIT <= LOAD_MODEL_KIND; // RL7
    end

    // Discharge cycle bookkeeping
    assign dsg_now = MEAN_CURRENT_VALUE < -$signed({1'b0, DSG_THRESHOLD});
    assign inst_power = ctf_pkg::power_10mw(MEAN_CURRENT_VALUE, CELL_VOLTAGE);
    assign div_start = MEAS_UPDATE && dsg_now
                       && dsg_count != ctf_pkg::COUNT_MAX;

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            in_dsg         <= 1'b0;
            dsg_count      <= '0;
            sum_i          <= '0;
            sum_p          <= '0;
            AVG_I_LAST_RUN <= ctf_pkg::AVG_I_LAST_RST;
            AVG_P_LAST_RUN <= ctf_pkg::AVG_P_LAST_RST;
        end
        else if (MEAS_UPDATE)
        begin
            in_dsg <= dsg_now;
            // Sums freeze at a full count so the average stays consistent
            if (div_start)
            begin
                dsg_count <= dsg_count + 16'h0001;
                sum_i <= sum_i
                         + ctf_pkg::SUM_W'(-(17'(MEAN_CURRENT_VALUE))); // RL12
                sum_p <= sum_p + ctf_pkg::SUM_W'(-(17'(inst_power)));
            end
            else if (!dsg_now && in_dsg)
            begin
                AVG_I_LAST_RUN <= avg_i_now; // RL12
                AVG_P_LAST_RUN <= avg_p_now;
                dsg_count      <= '0;
                sum_i          <= '0;
                sum_p          <= '0;
            end
        end
    end

    // Divides start with a sum update and take the new sum; count holds the new value
    ctf_div u_div_i (
        .clk      (CLK),
        .rst      (SYS_RST),
        .start    (div_start),
        .dividend (sum_i + ctf_pkg::SUM_W'(-(17'(MEAN_CURRENT_VALUE)))),
        .divisor  (dsg_count + 16'h0001),
        .busy     (),
        .done     (div_i_done),
        .quotient (quo_i)
    );

    ctf_div u_div_p (
        .clk      (CLK),
        .rst      (SYS_RST),
        .start    (div_start),
        .dividend (sum_p + ctf_pkg::SUM_W'(-(17'(inst_power)))),
        .divisor  (dsg_count + 16'h0001),
        .busy     (),
        .done     (div_p_done),
        .quotient (quo_p)
    );

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            avg_i_now <= '0;
            avg_p_now <= '0;
        end
        else
        begin
            if (div_i_done)
                avg_i_now <= ctf_pkg::VAL_W'(-(17'(quo_i[16:0]))); // RL12
            if (div_p_done)
                avg_p_now <= ctf_pkg::VAL_W'(-(17'(quo_p[16:0])));
        end
    end

    // First-order low-pass of the mean current, one step every FILT_STEP clocks
    assign filt_diff = (ctf_pkg::FILT_W+1)'(
                           $signed({MEAN_CURRENT_VALUE, 8'h00}))
                       - (ctf_pkg::FILT_W+1)'(filt_acc);
    assign filt_cur  = filt_acc[ctf_pkg::FILT_W-1:ctf_pkg::FILT_FRAC];

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            filt_tick_cnt <= 32'h0000_0000;
            filt_acc      <= '0;
        end
        else if (filt_tick_cnt >= FILT_STEP - 32'h0000_0001)
        begin
            filt_tick_cnt <= 32'h0000_0000;
            filt_acc <= filt_acc + ctf_pkg::FILT_W'(
                            filt_diff >>> ctf_pkg::FILT_SHIFT); // RL9
        end
        else
            filt_tick_cnt <= filt_tick_cnt + 32'h0000_0001;
    end

    // Load rate source: mA in constant current, 10 mW in constant power
    always_comb
    begin
        next_rate    = '0;
        next_invalid = 1'b0;
        unique case (ctf_pkg::ctf_select_t'(LOAD_MODEL_OPTION))
            ctf_pkg::SEL_LAST_CYCLE:
                next_rate = LOAD_MODEL_KIND ? AVG_P_LAST_RUN   // RL10
                                            : AVG_I_LAST_RUN;  // RL8
            ctf_pkg::SEL_THIS_CYCLE:
                next_rate = LOAD_MODEL_KIND ? avg_p_now : avg_i_now; // RL8
            ctf_pkg::SEL_AVERAGE:
                next_rate = LOAD_MODEL_KIND ? inst_power  // RL10
                                            : MEAN_CURRENT_VALUE; // RL8
            ctf_pkg::SEL_FILTERED:
                next_rate = LOAD_MODEL_KIND
                    ? ctf_pkg::power_10mw(filt_cur, CELL_VOLTAGE) // RL11
                    : filt_cur; // RL9
            ctf_pkg::SEL_DESIGN_FIFTH:
                next_rate = LOAD_MODEL_KIND
                    ? ctf_pkg::VAL_W'(-(17'(DESIGN_ENERGY
                                            / ctf_pkg::ENERGY_DIV))) // RL11
                    : ctf_pkg::VAL_W'(-(17'(DESIGN_CAPACITY
                                            / ctf_pkg::DESIGN_FIFTH))); // RL9
            ctf_pkg::SEL_HYPOTHETICAL:
                next_rate = HYPOTHETICAL_RATE_VALUE; // RL9
            ctf_pkg::SEL_CUSTOM:
                next_rate = CUSTOM_RATE_VALUE; // RL11
            default:
                next_invalid = 1'b1;
        endcase
    end

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            LOAD_RATE_VALUE     <= '0;
            LOAD_OPTION_INVALID <= 1'b0;
        end
        else
        begin
            LOAD_RATE_VALUE     <= next_rate; // RL6
            LOAD_OPTION_INVALID <= next_invalid;
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            CHARGE_ACCUM <= '0;
        else if (MEAS_UPDATE)
            CHARGE_ACCUM <= CHARGE_ACCUM
                            + ctf_pkg::ACC_W'(CHARGE_DELTA); // RL14
    end

    // Reserve is kept at no-load value: no rate scaling is applied to it
    assign draw = CHARGE_DELTA[ctf_pkg::VAL_W-1]
                  ? (ctf_pkg::VAL_W+1)'(-(17'(CHARGE_DELTA))) : '0;

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            reserve_left <= '0;
        else if (MEAS_UPDATE)
        begin
            if (CAPACITY_LEFT_VALUE != '0)
                reserve_left <= {RESERVE_CHARGE_AMOUNT,
                                 ctf_pkg::CAP_FRAC'(0)}; // RL13
            else if (CELL_VOLTAGE <= TERMINATE_VOLTAGE)
                reserve_left <= '0;
            else if (reserve_left > ctf_pkg::RES_W'(draw))
                reserve_left <= reserve_left - ctf_pkg::RES_W'(draw); // RL13
            else
                reserve_left <= '0;
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            RESERVE_LEFT_VALUE <= '0;
        else
            RESERVE_LEFT_VALUE <= reserve_left[ctf_pkg::RES_W-1:
                                                ctf_pkg::CAP_FRAC];
    end

endmodule

// File: ctf_pkg.sv
package ctf_pkg;

    localparam int VAL_W = 16;
    localparam int ACC_W = 32;
    localparam int SUM_W = 48;
    localparam int FILT_W = 24;
    localparam int FILT_FRAC = 8;
    localparam int FILT_SHIFT = 4;
    localparam int CAP_FRAC = 10;
    localparam int RES_W = VAL_W + CAP_FRAC;

    // Load model kind, encoded 0 and 1 in declaration order
    typedef enum logic {
        CTF_CONST_CURRENT,
        CTF_CONST_POWER
    } ctf_model_t;

    typedef enum logic [2:0] {
        SEL_LAST_CYCLE,
        SEL_THIS_CYCLE,
        SEL_AVERAGE,
        SEL_FILTERED,
        SEL_DESIGN_FIFTH,
        SEL_HYPOTHETICAL,
        SEL_CUSTOM
    } ctf_select_t;

    localparam logic       MODEL_DEFAULT  = 1'h0;
    localparam logic [2:0] SEL_CC_DEFAULT = 3'h1;
    localparam logic [2:0] SEL_CP_DEFAULT = 3'h0;

    // Previous-cycle averages after reset: -300 mA and -1200
    localparam logic signed [VAL_W-1:0] AVG_I_LAST_RST = 16'hFED4;
    localparam logic signed [VAL_W-1:0] AVG_P_LAST_RST = 16'hFB50;

    // Filter time constant and its step period at the system clock
    localparam longint unsigned TAU_FILT_MS = 64'h0000_0000_0000_36B0;
    localparam longint unsigned CLK_KHZ     = 64'h0000_0000_0003_0D40;
    localparam longint unsigned FILT_STEP_CYCLES =
        (TAU_FILT_MS * CLK_KHZ) >> FILT_SHIFT;

    // mA times mV is uW; 10000 uW make one 10 mW unit
    localparam logic signed [33:0] POWER_DIV = 34'sh0_0000_2710;
    localparam logic signed [33:0] POWER_MAX = 34'sh0_0000_7FFF;
    localparam logic signed [33:0] POWER_MIN = 34'sh3_FFFF_8000;
    localparam logic [VAL_W-1:0]   DESIGN_FIFTH = 16'h0005;
    // mWh / 5 is mW; a further / 10 gives 10 mW units
    localparam logic [VAL_W-1:0]   ENERGY_DIV   = 16'h0032;

    localparam logic [VAL_W-1:0]   COUNT_MAX = 16'hFFFF;

    // Current times voltage in 10 mW units, saturated to 16 bits
    function automatic logic signed [VAL_W-1:0] power_10mw(
        input logic signed [VAL_W-1:0] cur,
        input logic [VAL_W-1:0]        volt
    );
        logic signed [33:0] prod;
        logic signed [33:0] quo;
        prod = 34'(cur) * 34'(signed'({1'b0, volt}));
        quo = prod / POWER_DIV;
        if (quo > POWER_MAX)
            return 16'h7FFF;
        else if (quo < POWER_MIN)
            return 16'h8000;
        else
            return quo[VAL_W-1:0];
    endfunction

endpackage

// File: ctf_div.sv
`timescale 1ns/1ps

// Serial restoring divider, one quotient bit per clock
module ctf_div (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       start,
    input  wire logic [ctf_pkg::SUM_W-1:0]  dividend,
    input  wire logic [ctf_pkg::VAL_W-1:0]  divisor,
    output logic                            busy,
    output logic                            done,
    output logic [ctf_pkg::SUM_W-1:0]       quotient
);

    logic [ctf_pkg::VAL_W:0]   rem;
    logic [ctf_pkg::VAL_W:0]   trial;
    logic [ctf_pkg::SUM_W-1:0] work;
    logic [ctf_pkg::VAL_W-1:0] dvs;
    logic [5:0]                steps;

    assign trial = {rem[ctf_pkg::VAL_W-1:0], work[ctf_pkg::SUM_W-1]};

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rem      <= '0;
            work     <= '0;
            dvs      <= '0;
            steps    <= 6'h00;
            busy     <= 1'b0;
            done     <= 1'b0;
            quotient <= '0;
        end
        else
        begin
            done <= 1'b0;
            // A start while busy is dropped; the next one recomputes
            if (start && !busy)
            begin
                rem   <= '0;
                work  <= dividend;
                dvs   <= divisor;
                steps <= 6'(ctf_pkg::SUM_W);
                busy  <= 1'b1;
            end
            else if (busy)
            begin
                if (trial >= {1'b0, dvs})
                begin
                    rem  <= trial - {1'b0, dvs};
                    work <= {work[ctf_pkg::SUM_W-2:0], 1'b1};
                end
                else
                begin
                    rem  <= trial;
                    work <= {work[ctf_pkg::SUM_W-2:0], 1'b0};
                end
                steps <= steps - 6'h01;
                if (steps == 6'h01)
                begin
                    busy <= 1'b0;
                    done <= 1'b1;
                    if (trial >= {1'b0, dvs})
                        quotient <= {work[ctf_pkg::SUM_W-2:0], 1'b1};
                    else
                        quotient <= {work[ctf_pkg::SUM_W-2:0], 1'b0};
                end
            end
        end
    end

endmodule

// File: ctf_flags_load_asserts.sv
`timescale 1ns/1ps

module ctf_flags_load_check (
    input wire logic                             CLK,
    input wire logic                             SYS_RST,
    input wire logic                             MEAS_UPDATE,
    input wire logic [ctf_pkg::VAL_W-1:0]        CAPACITY_LEFT_VALUE,
    input wire logic [ctf_pkg::VAL_W-1:0]        CELL_VOLTAGE,
    input wire logic [ctf_pkg::VAL_W-1:0]        INITIAL_CHARGE_SET_LEVEL,
    input wire logic [ctf_pkg::VAL_W-1:0]        SHUTDOWN_SET_LEVEL,
    input wire logic [ctf_pkg::VAL_W-1:0]        SHUTDOWN_CLEAR_LEVEL,
    input wire logic signed [ctf_pkg::VAL_W-1:0] HYPOTHETICAL_RATE_VALUE,
    input wire logic signed [ctf_pkg::VAL_W-1:0] CUSTOM_RATE_VALUE,
    input wire logic                             LOAD_MODEL_KIND,
    input wire logic [2:0]                       LOAD_MODEL_OPTION,
    input wire logic                             LOW_CHARGE_FLAG,
    input wire logic                             SHUTDOWN_WARNING_FLAG,
    input wire logic                             BATTERY_LOW_PIN,
    input wire logic                             SOC_INT_PIN,
    input wire logic                             LOAD_MODEL_STATUS_BIT,
    input wire logic signed [ctf_pkg::VAL_W-1:0] LOAD_RATE_VALUE,
    input wire logic                             LOAD_OPTION_INVALID
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);

    // Set is checked first, so a rise only counts at or above the set level too
    sequence s_drop;
        MEAS_UPDATE && !SHUTDOWN_WARNING_FLAG
            && CELL_VOLTAGE < SHUTDOWN_SET_LEVEL;
    endsequence
    sequence s_rise;
        MEAS_UPDATE && SHUTDOWN_WARNING_FLAG
            && CELL_VOLTAGE > SHUTDOWN_CLEAR_LEVEL
            && CELL_VOLTAGE >= SHUTDOWN_SET_LEVEL;
    endsequence

    a_pin_tracks_flag: assert property (BATTERY_LOW_PIN == LOW_CHARGE_FLAG)
        else $error("battery-low pin differs from low-charge flag");
    a_low_set: assert property (MEAS_UPDATE
        && CAPACITY_LEFT_VALUE < INITIAL_CHARGE_SET_LEVEL |=> LOW_CHARGE_FLAG)
        else $error("low-charge flag not set");
    a_low_clear: assert property (MEAS_UPDATE
        && CAPACITY_LEFT_VALUE > INITIAL_CHARGE_SET_LEVEL |=> !LOW_CHARGE_FLAG)
        else $error("low-charge flag not cleared");
    a_flags_hold: assert property (!MEAS_UPDATE |=> $stable(LOW_CHARGE_FLAG)
        && $stable(SHUTDOWN_WARNING_FLAG))
        else $error("flag moved without a measurement update");
    a_warn_set: assert property (s_drop |=> SHUTDOWN_WARNING_FLAG && SOC_INT_PIN)
        else $error("shutdown warning not raised with interrupt");
    a_warn_clear: assert property (s_rise |=> !SHUTDOWN_WARNING_FLAG && SOC_INT_PIN)
        else $error("shutdown warning not cleared with interrupt");
    a_int_on_change: assert property (SOC_INT_PIN == $changed(SHUTDOWN_WARNING_FLAG))
        else $error("interrupt pulse not tied to warning change");
    a_status_mirror: assert property (1'b1 |=>
        LOAD_MODEL_STATUS_BIT == $past(LOAD_MODEL_KIND))
        else $error("status bit does not mirror load-model kind");
    a_rate_hypo: assert property (LOAD_MODEL_OPTION == 3'h5 |=>
        LOAD_RATE_VALUE == $past(HYPOTHETICAL_RATE_VALUE))
        else $error("option five does not pick the hypothetical rate");
    a_rate_custom: assert property (LOAD_MODEL_OPTION == 3'h6 |=>
        LOAD_RATE_VALUE == $past(CUSTOM_RATE_VALUE))
        else $error("option six does not pick the custom rate");
    a_bad_option: assert property (LOAD_MODEL_OPTION == 3'h7 |=>
        LOAD_OPTION_INVALID && LOAD_RATE_VALUE == 16'h0000)
        else $error("option seven not flagged invalid with zero rate");
endmodule

bind ctf_flags_load ctf_flags_load_check u_check (
    .CLK(CLK), .SYS_RST(SYS_RST), .MEAS_UPDATE(MEAS_UPDATE),
    .CAPACITY_LEFT_VALUE(CAPACITY_LEFT_VALUE), .CELL_VOLTAGE(CELL_VOLTAGE),
    .INITIAL_CHARGE_SET_LEVEL(INITIAL_CHARGE_SET_LEVEL),
    .SHUTDOWN_SET_LEVEL(SHUTDOWN_SET_LEVEL),
    .SHUTDOWN_CLEAR_LEVEL(SHUTDOWN_CLEAR_LEVEL),
    .HYPOTHETICAL_RATE_VALUE(HYPOTHETICAL_RATE_VALUE),
    .CUSTOM_RATE_VALUE(CUSTOM_RATE_VALUE), .LOAD_MODEL_KIND(LOAD_MODEL_KIND),
    .LOAD_MODEL_OPTION(LOAD_MODEL_OPTION), .LOW_CHARGE_FLAG(LOW_CHARGE_FLAG),
    .SHUTDOWN_WARNING_FLAG(SHUTDOWN_WARNING_FLAG),
    .BATTERY_LOW_PIN(BATTERY_LOW_PIN), .SOC_INT_PIN(SOC_INT_PIN),
    .LOAD_MODEL_STATUS_BIT(LOAD_MODEL_STATUS_BIT),
    .LOAD_RATE_VALUE(LOAD_RATE_VALUE), .LOAD_OPTION_INVALID(LOAD_OPTION_INVALID)
);

// File: ctf_host_model.sv
`timescale 1ns/1ps

// Gauge-side sampler: measurement words with a one-cycle strobe
module ctf_host_model (
    input  wire logic                        clk,
    output logic                             meas_update,
    output logic [ctf_pkg::VAL_W-1:0]        capacity_left_value,
    output logic [ctf_pkg::VAL_W-1:0]        cell_voltage,
    output logic signed [ctf_pkg::VAL_W-1:0] mean_current_value,
    output logic signed [ctf_pkg::VAL_W-1:0] charge_delta
);
    initial
    begin
        meas_update = 1'h0;
        capacity_left_value = 16'h01F4;
        cell_voltage = 16'h0E74;
        mean_current_value = 16'sh0000;
        charge_delta = 16'sh0000;
    end

    // Words stay put after the strobe: the current also feeds the filter
    task automatic send(
        input logic [15:0]        c,
        input logic [15:0]        v,
        input logic signed [15:0] i,
        input logic signed [15:0] d
    );
        @(negedge clk);
        capacity_left_value = c;
        cell_voltage = v;
        mean_current_value = i;
        charge_delta = d;
        meas_update = 1'h1;
        @(negedge clk);
        meas_update = 1'h0;
    endtask
endmodule

// File: test_ctf_flags_load.sv
`timescale 1ns/1ps

module test_ctf_flags_load;
    logic               clk = 1'h0;
    logic               rst;
    logic               upd;
    logic [15:0]        cap;
    logic [15:0]        volt;
    logic signed [15:0] cur;
    logic signed [15:0] dlt;
    logic               kind;
    logic [2:0]         opt;
    logic               low;
    logic               sdw;
    logic               blp;
    logic               sint;
    logic               stat;
    logic               inv;
    logic signed [15:0] rate;
    logic signed [15:0] avg_i;
    logic signed [15:0] avg_p;
    logic signed [31:0] acc;
    logic [15:0]        resl;
    logic signed [15:0] hyp = -16'sh00FA;
    logic signed [15:0] cus = -16'sh004D;
    logic [15:0]        dcap = 16'h03E8;
    logic [15:0]        deng = 16'h0E74;
    logic [15:0]        thr = 16'h000A;
    int                 error_cnt = 0;
    int                 cmp_count = 0;

    always #2.5 clk = ~clk;

    ctf_host_model u_host (.clk(clk), .meas_update(upd),
        .capacity_left_value(cap), .cell_voltage(volt),
        .mean_current_value(cur), .charge_delta(dlt));

    // Short filter step keeps convergence within a few thousand cycles
    ctf_flags_load #(.FILT_STEP(16)) u_dut (
        .CLK(clk), .SYS_RST(rst), .MEAS_UPDATE(upd),
        .CAPACITY_LEFT_VALUE(cap), .CELL_VOLTAGE(volt),
        .MEAN_CURRENT_VALUE(cur), .CHARGE_DELTA(dlt),
        .INITIAL_CHARGE_SET_LEVEL(16'h0064), .SHUTDOWN_SET_LEVEL(16'h0BB8),
        .SHUTDOWN_CLEAR_LEVEL(16'h0C80), .TERMINATE_VOLTAGE(16'h0BB8),
        .RESERVE_CHARGE_AMOUNT(16'h0014), .DSG_THRESHOLD(thr),
        .DESIGN_CAPACITY(dcap), .DESIGN_ENERGY(deng),
        .HYPOTHETICAL_RATE_VALUE(hyp), .CUSTOM_RATE_VALUE(cus),
        .LOAD_MODEL_KIND(kind), .LOAD_MODEL_OPTION(opt),
        .LOW_CHARGE_FLAG(low), .SHUTDOWN_WARNING_FLAG(sdw),
        .BATTERY_LOW_PIN(blp), .SOC_INT_PIN(sint),
        .LOAD_MODEL_STATUS_BIT(stat), .LOAD_RATE_VALUE(rate),
        .LOAD_OPTION_INVALID(inv), .AVG_I_LAST_RUN(avg_i),
        .AVG_P_LAST_RUN(avg_p), .CHARGE_ACCUM(acc),
        .RESERVE_LEFT_VALUE(resl));

    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    // Expected {low, warning, interrupt} one cycle after the strobe
    task automatic meas(
        input logic [15:0]        c,
        input logic [15:0]        v,
        input logic signed [15:0] i,
        input logic signed [15:0] d,
        input logic [2:0]         e
    );
        u_host.send(c, v, i, d);
        check(low, e[2]);
        check(blp, e[2]);
        check(sdw, e[1]);
        check(sint, e[0]);
        @(negedge clk);
        check(sint, 1'h0);
        // Spacing lets the serial divide finish before the next sample
        repeat (50) @(negedge clk);
    endtask

    task automatic cfg(
        input logic               k,
        input logic [2:0]         o,
        input logic signed [15:0] e
    );
        kind = k;
        opt = o;
        repeat (2) @(negedge clk);
        check(rate, e);
        check(stat, k);
        check(inv, o == 3'h7);
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        stop_test();
    end

    initial
    begin
        rst = 1'h1;
        kind = 1'h0;
        opt = 3'h1;
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst = 1'h0;
        check(avg_i, -16'sh012C);
        check(avg_p, -16'sh04B0);
        meas(16'h01F4, 16'h0E74, -16'sh0064, -16'sh0066, 3'h0);
        meas(16'h0063, 16'h0E74, -16'sh0064, -16'sh0066, 3'h4);
        meas(16'h0064, 16'h0E74, -16'sh0064, -16'sh0066, 3'h4);
        meas(16'h0065, 16'h0BB7, -16'sh0064, -16'sh0066, 3'h3);
        meas(16'h0065, 16'h0C1C, -16'sh0064, -16'sh0066, 3'h2);
        meas(16'h0065, 16'h0C80, -16'sh0064, -16'sh0066, 3'h2);
        check(acc, -32'sh0000_0264);
        repeat (5) @(negedge clk);
        check(rate, -16'sh0064);
        check(resl, 16'h0014);
        meas(16'h0000, 16'h0C81, 16'sh0000, 16'sh0000, 3'h5);
        check(avg_i, -16'sh0064);
        check(resl, 16'h0014);
        meas(16'h0000, 16'h0C1C, -16'sh07D0, -16'sh0C00, 3'h4);
        check(resl, 16'h0011);
        meas(16'h0000, 16'h0BB8, -16'sh01F4, 16'sh0000, 3'h4);
        check(resl, 16'h0000);
        repeat (4000) @(negedge clk);
        cfg(1'h0, 3'h0, -16'sh0064);
        cfg(1'h0, 3'h1, -16'sh04E2);
        cfg(1'h0, 3'h2, -16'sh01F4);
        cfg(1'h0, 3'h3, -16'sh01F4);
        cfg(1'h0, 3'h4, -16'sh00C8);
        cfg(1'h0, 3'h5, -16'sh00FA);
        cfg(1'h0, 3'h6, -16'sh004D);
        cfg(1'h1, 3'h0, -16'sh0021);
        cfg(1'h1, 3'h1, -16'sh0181);
        cfg(1'h1, 3'h2, -16'sh0096);
        cfg(1'h1, 3'h3, -16'sh0096);
        cfg(1'h1, 3'h4, -16'sh004A);
        hyp = 16'sh0123;
        cfg(1'h1, 3'h5, 16'sh0123);
        cfg(1'h1, 3'h6, -16'sh004D);
        cfg(1'h1, 3'h7, 16'sh0000);
        stop_test();
    end
endmodule
